// ===== common/dso_pkg.sv
// Package: register map, field codes and timing constants of the drive status output selector
package dso_pkg;
    // -----------------------------------------------------------------
    // Register byte offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] DSO_OFS_FREQ = 8'h00; // Ref [15:0], output [31:16], read/write
    localparam logic [7:0] DSO_OFS_FDT = 8'h04; // Detect freq [15:0], bandwidth [31:16]
    localparam logic [7:0] DSO_OFS_SEL = 8'h08; // Four 5-bit function selects
    localparam logic [7:0] DSO_OFS_MASK = 8'h0C; // Fault relay mask [2:0]
    localparam logic [7:0] DSO_OFS_OLW = 8'h10; // Warning level [15:0], time in ms [31:16]
    localparam logic [7:0] DSO_OFS_STAT = 8'h14; // Drive status inputs, software written
    localparam logic [7:0] DSO_OFS_CUR = 8'h18; // Output current [15:0], rated [31:16]
    localparam logic [7:0] DSO_OFS_SRC = 8'h1C; // Sources and local/remote control
    localparam logic [7:0] DSO_OFS_OUT = 8'h20; // Read only: outputs and state
    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int DSO_SEL_W = 5; // Width of one function select
    localparam int DSO_SRC_KEY_BIT = 16; // Write 1: operator key press
    localparam int DSO_SRC_ASSIGN_BIT = 17; // Digital input assigned to local/remote
    localparam int DSO_SRC_APP_BIT = 18; // Application mode is multi-motor
    // -----------------------------------------------------------------
    // Reset values and codes
    // -----------------------------------------------------------------
    localparam logic [2:0] DSO_MASK_RST = 3'h2; // Trip bit only
    localparam logic [3:0] DSO_KEYPAD = 4'h0; // Keypad source code
    localparam logic [4:0] DSO_FN_PUMP = 5'h14; // Pump control function code
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int DSO_CLK_HZ = 50000000; // Clock rate
    localparam int DSO_MS_CYC = DSO_CLK_HZ / 1000; // Cycles per millisecond
    localparam int DSO_IOL_S = 60; // Drive overload warning time, seconds
    localparam int DSO_IOL_MS = DSO_IOL_S * 1000; // Same time in milliseconds
    localparam int DSO_IOL_PCT = 110; // Drive overload threshold, percent of rated
    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef enum logic [4:0] {
        DSO_FN_NONE = 5'h00, DSO_FN_ARRIVE = 5'h01, DSO_FN_LEVEL = 5'h02,
        DSO_FN_BAND = 5'h03, DSO_FN_HYST = 5'h04, DSO_FN_HYST_N = 5'h05,
        DSO_FN_OLW = 5'h06, DSO_FN_IOL = 5'h07, DSO_FN_STALL = 5'h08,
        DSO_FN_OV = 5'h09, DSO_FN_LV = 5'h0A, DSO_FN_OH = 5'h0B,
        DSO_FN_LOST = 5'h0C, DSO_FN_RUN = 5'h0D, DSO_FN_STOP = 5'h0E,
        DSO_FN_STEADY = 5'h0F, DSO_FN_DRVLINE = 5'h10, DSO_FN_MAINS = 5'h11,
        DSO_FN_SEARCH = 5'h12, DSO_FN_READY = 5'h13, DSO_FN_PUMPC = 5'h14
    } dso_fn_t;
    // Drive status bits, written by software from the drive's control loop
    typedef struct packed {
        logic pump_req; logic mains_line; logic drive_line; logic ready; logic search;
        logic steady; logic running; logic lost_ref; logic overheat; logic undervolt;
        logic overvolt; logic stall; logic accel; logic lv_trip; logic drive_disable_fault;
        logic other_fault; logic retry_zero; logic auto_retry;
    } dso_stat_t;
    // AHB-Lite slave signals
    typedef struct packed {
        logic hsel; logic [31:0] haddr; logic [1:0] htrans; logic hwrite;
        logic [2:0] hsize; logic hready; logic [31:0] hwdata;
    } dso_ahb_in_t;
    typedef struct packed {
        logic [31:0] hrdata; logic hreadyout; logic hresp;
    } dso_ahb_out_t;
endpackage : dso_pkg

// ===== core/dso_timer.sv
// Persistence timer: asserts once its condition has held for a set number of ticks
`timescale 1ns/1ps
module dso_timer #(
    parameter int W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick, // One-cycle time base enable
    input wire logic cond, // Condition being timed
    input wire logic [W-1:0] limit, // Ticks the condition must persist
    output logic done // Condition held long enough
);
    logic [W-1:0] cnt_q;
    // -----------------------------------------------------------------
    // Counter: any break in the condition restarts the wait
    // -----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (!cond) begin
            cnt_q <= '0;
        end else if (tick && cnt_q < limit) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    assign done = cond && (cnt_q >= limit);
endmodule : dso_timer

// ===== core/dso_top.sv
// Drive status output selector: four output contacts, fault relay, local/remote source choice
//
// Overview of operation
// - Arrival: close when reference near output frequency
// - Level: arrival and output near detect frequency
// - Band: closed while output within detect band
// - Hysteresis: accel at detect, decel above lower
// - Inverted hysteresis is exact complement of hysteresis
// - Overload warning after level held warning time
// - Drive overload: above 110% for 60 seconds
// - Stall, low voltage, overheat, lost reference select
// - Running, stopped or steady speed select
// - Speed search or ready select
// - Multi-motor mode forces pump-control output function
// - Mask bit 001 gates low-voltage trip
// - Mask bit 010 gates other non-disable faults
// - Mask bit 100 gates retry exhausted, not autoretry
// - Priority low-voltage, trip, retry; default 010
// - No input assigned: key toggles, starts remote
// - Local forces keypad control and frequency sources
// - Input assigned: key ignored, off local, on remote
// - Remote loads the two remote source settings
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module dso_top
    import dso_pkg::*;
#(
    parameter int FW = 16, // Frequency and current width
    parameter int IOL_MS = DSO_IOL_MS // Drive overload time in ms, shortenable
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire dso_pkg::dso_ahb_in_t ahb_i,
    output dso_pkg::dso_ahb_out_t ahb_o,
    input wire logic loc_rem_pin, // Digital input for local/remote, from outside
    output logic [3:0] output_contact_a, // Contact closed when high
    output logic fault_relay, // Relay energised: normally open closes
    output logic [2:0] fault_cause, // One-hot cause: 001 low voltage, 010 trip, 100 retry
    output logic remote_q, // High in remote operation
    output logic [3:0] ctrl_source, // Active control source
    output logic [3:0] freq_source, // Active frequency source
    output logic iol_trip // Drive overload trip, output cut off
);
    import dso_pkg::*;
    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [31:0] freq_q, fdt_q, olw_q, cur_q; // Software setpoints and measurements
    logic [19:0] sel_q; // Function selects
    logic [2:0] mask_q; // Fault relay mask
    dso_stat_t stat_q; // Drive status
    logic [15:0] rsrc_q; // Remote ctrl [3:0], remote freq [7:4]
    logic assign_q, app_mmc_q; // Input assignment, multi-motor mode
    logic key_q; // Key press pulse from a write
    logic local_key_q; // Local state set by the key
    logic [1:0] pin_sync_q; // Two-stage pin synchroniser
    logic [15:0] ms_cnt_q; // Millisecond divider
    logic ms_tick_q; // One-cycle millisecond enable
    logic [3:0] contact_q;
    logic relay_q, iol_trip_q;
    logic [2:0] cause_q;
    logic [3:0] csrc_q, fsrc_q;
    logic rem_q;
    // Bus phase capture
    logic wr_pend_q, rd_pend_q;
    logic [7:0] addr_q;
    logic [31:0] rdata_q;
    // -----------------------------------------------------------------
    // Bus decode: zero wait states, always OKAY
    // -----------------------------------------------------------------
    wire xfer = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
    wire take_wr = xfer && ahb_i.hwrite;
    wire take_rd = xfer && !ahb_i.hwrite;
    wire [31:0] wd = ahb_i.hwdata;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take_wr;
            rd_pend_q <= take_rd;
            addr_q <= xfer ? ahb_i.haddr[7:0] : addr_q;
        end
    end
    wire wr_ok = wr_pend_q && (addr_q[1:0] == 2'h0);
    // -----------------------------------------------------------------
    // Register writes (data phase)
    // -----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_q <= 32'h0; fdt_q <= 32'h0; olw_q <= 32'h0; cur_q <= 32'h0;
            sel_q <= 20'h0; mask_q <= DSO_MASK_RST; stat_q <= '0;
            rsrc_q <= 16'h0; assign_q <= 1'b0; app_mmc_q <= 1'b0; key_q <= 1'b0;
        end else begin
            key_q <= 1'b0;
            if (wr_ok) begin
                unique case (addr_q)
                    DSO_OFS_FREQ: freq_q <= wd;
                    DSO_OFS_FDT: fdt_q <= wd;
                    DSO_OFS_SEL: sel_q <= wd[19:0];
                    DSO_OFS_MASK: mask_q <= wd[2:0];
                    DSO_OFS_OLW: olw_q <= wd;
                    DSO_OFS_STAT: stat_q <= wd[$bits(dso_stat_t)-1:0];
                    DSO_OFS_CUR: cur_q <= wd;
                    DSO_OFS_SRC: begin
                        rsrc_q <= wd[15:0];
                        key_q <= wd[DSO_SRC_KEY_BIT];
                        assign_q <= wd[DSO_SRC_ASSIGN_BIT];
                        app_mmc_q <= wd[DSO_SRC_APP_BIT];
                    end
                    default: begin
                        // Unmapped: write ignored
                    end
                endcase
            end
        end
    end
    // -----------------------------------------------------------------
    // Millisecond enable from the 50 MHz clock
    // -----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_cnt_q <= 16'h0;
            ms_tick_q <= 1'b0;
        end else begin
            ms_tick_q <= (ms_cnt_q == 16'(DSO_MS_CYC - 1));
            ms_cnt_q <= (ms_cnt_q == 16'(DSO_MS_CYC - 1)) ? 16'h0 : ms_cnt_q + 16'h1;
        end
    end
    // -----------------------------------------------------------------
    // Frequency comparisons, unsigned: larger minus smaller keeps differences honest
    // -----------------------------------------------------------------
    wire [FW-1:0] f_ref = freq_q[FW-1:0];
    wire [FW-1:0] f_out = freq_q[16 +: FW];
    wire [FW-1:0] f_det = fdt_q[FW-1:0];
    wire [FW-1:0] half_bw = fdt_q[16 +: FW] >> 1;
    wire [FW:0] d_ref = (f_ref > f_out) ? {1'b0, f_ref - f_out} : {1'b0, f_out - f_ref};
    wire [FW:0] d_det = (f_det > f_out) ? {1'b0, f_det - f_out} : {1'b0, f_out - f_det};
    wire arrive = d_ref <= {1'b0, half_bw};
    wire level = arrive && (d_det <= {1'b0, half_bw});
    wire band = d_det <= {1'b0, half_bw};
    // Lower threshold clamps at zero so a wide band cannot wrap around
    wire [FW-1:0] hyst_lo = (f_det > half_bw) ? f_det - half_bw : '0;
    wire hyst = stat_q.accel ? (f_out >= f_det) : (f_out > hyst_lo);
    wire hyst_n = !hyst;
    // -----------------------------------------------------------------
    // Overload timers
    // -----------------------------------------------------------------
    wire [FW-1:0] i_out = cur_q[FW-1:0];
    wire [FW-1:0] i_rated = cur_q[16 +: FW];
    // 100 x current against 110 x rated, widened to avoid overflow
    wire [FW+7:0] i_out_x = (FW+8)'(i_out) * (FW+8)'(100);
    wire [FW+7:0] i_rat_x = (FW+8)'(i_rated) * (FW+8)'(DSO_IOL_PCT);
    wire olw_done, iol_warn, iol_cut;
    dso_timer #(.W(16)) u_olw (
        .hclk(hclk), .hresetn(hresetn), .tick(ms_tick_q),
        .cond(i_out >= olw_q[FW-1:0]), .limit(olw_q[31:16]), .done(olw_done)
    );
    dso_timer #(.W(18)) u_iol (
        .hclk(hclk), .hresetn(hresetn), .tick(ms_tick_q),
        .cond(i_out_x > i_rat_x), .limit(18'(IOL_MS)), .done(iol_warn)
    );
    // Trip after a further minute of overload
    dso_timer #(.W(18)) u_iolc (
        .hclk(hclk), .hresetn(hresetn), .tick(ms_tick_q),
        .cond(iol_warn), .limit(18'(IOL_MS)), .done(iol_cut)
    );
    // -----------------------------------------------------------------
    // Per-contact function selection
    // -----------------------------------------------------------------
    logic [3:0] contact_d;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ct
            // Multi-motor mode overrides the programmed selection
            wire [4:0] fsel = app_mmc_q ? DSO_FN_PUMP : sel_q[g*DSO_SEL_W +: DSO_SEL_W];
            logic hit;
            always_comb begin
                unique case (fsel)
                    DSO_FN_ARRIVE: hit = arrive;
                    DSO_FN_LEVEL: hit = level;
                    DSO_FN_BAND: hit = band;
                    DSO_FN_HYST: hit = hyst;
                    DSO_FN_HYST_N: hit = hyst_n;
                    DSO_FN_OLW: hit = olw_done;
                    DSO_FN_IOL: hit = iol_warn;
                    DSO_FN_STALL: hit = stat_q.stall;
                    DSO_FN_OV: hit = stat_q.overvolt;
                    DSO_FN_LV: hit = stat_q.undervolt;
                    DSO_FN_OH: hit = stat_q.overheat;
                    DSO_FN_LOST: hit = stat_q.lost_ref;
                    DSO_FN_RUN: hit = stat_q.running;
                    DSO_FN_STOP: hit = !stat_q.running;
                    DSO_FN_STEADY: hit = stat_q.steady;
                    DSO_FN_DRVLINE: hit = stat_q.drive_line;
                    DSO_FN_MAINS: hit = stat_q.mains_line;
                    DSO_FN_SEARCH: hit = stat_q.search;
                    DSO_FN_READY: hit = stat_q.ready;
                    DSO_FN_PUMPC: hit = stat_q.pump_req;
                    default: hit = 1'b0; // None or unused code: open
                endcase
            end
            assign contact_d[g] = hit;
        end
    endgenerate
    // -----------------------------------------------------------------
    // Fault relay: first active masked cause in priority order wins
    // -----------------------------------------------------------------
    wire c_lv = mask_q[0] && stat_q.lv_trip;
    wire c_trip = mask_q[1] && stat_q.other_fault && !stat_q.drive_disable_fault;
    wire c_retry = mask_q[2] && stat_q.retry_zero && !stat_q.auto_retry;
    wire [2:0] cause_d = c_lv ? 3'h1 : c_trip ? 3'h2 : c_retry ? 3'h4 : 3'h0;
    // -----------------------------------------------------------------
    // Local/remote selection
    // -----------------------------------------------------------------
    wire pin_on = pin_sync_q[1];
    wire remote_d = assign_q ? pin_on : !local_key_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_sync_q <= 2'h0;
            local_key_q <= 1'b0; // Powers up remote
        end else begin
            pin_sync_q <= {pin_sync_q[0], loc_rem_pin};
            // Key is ignored while an input owns the selection
            if (key_q && !assign_q) begin
                local_key_q <= !local_key_q;
            end
        end
    end
    // -----------------------------------------------------------------
    // Output flops
    // -----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            contact_q <= 4'h0; relay_q <= 1'b0; cause_q <= 3'h0; iol_trip_q <= 1'b0;
            rem_q <= 1'b1; csrc_q <= DSO_KEYPAD; fsrc_q <= DSO_KEYPAD;
        end else begin
            contact_q <= contact_d;
            cause_q <= cause_d;
            relay_q <= |cause_d;
            iol_trip_q <= iol_cut;
            rem_q <= remote_d;
            csrc_q <= remote_d ? rsrc_q[3:0] : DSO_KEYPAD;
            fsrc_q <= remote_d ? rsrc_q[7:4] : DSO_KEYPAD;
        end
    end
    // -----------------------------------------------------------------
    // Read data, registered for the data phase
    // -----------------------------------------------------------------
    wire [31:0] out_word = {12'h0, iol_trip_q, fsrc_q, csrc_q, rem_q, cause_q, relay_q, 2'h0,
                            contact_q};
    logic [31:0] rd_mux;
    always_comb begin
        unique case (ahb_i.haddr[7:0])
            DSO_OFS_FREQ: rd_mux = freq_q;
            DSO_OFS_FDT: rd_mux = fdt_q;
            DSO_OFS_SEL: rd_mux = {12'h0, sel_q};
            DSO_OFS_MASK: rd_mux = {29'h0, mask_q};
            DSO_OFS_OLW: rd_mux = olw_q;
            DSO_OFS_STAT: rd_mux = 32'(stat_q);
            DSO_OFS_CUR: rd_mux = cur_q;
            DSO_OFS_SRC: rd_mux = {13'h0, app_mmc_q, assign_q, 1'b0, rsrc_q};
            DSO_OFS_OUT: rd_mux = out_word;
            default: rd_mux = 32'h0; // Unmapped reads zero
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0;
        end else if (take_rd) begin
            rdata_q <= rd_mux;
        end
    end
    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign ahb_o.hrdata = rdata_q;
    assign ahb_o.hreadyout = 1'b1;
    assign ahb_o.hresp = 1'b0;
    assign output_contact_a = contact_q;
    assign fault_relay = relay_q;
    assign fault_cause = cause_q;
    assign remote_q = rem_q;
    assign ctrl_source = csrc_q;
    assign freq_source = fsrc_q;
    assign iol_trip = iol_trip_q;
    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    chk_none_open: assert property (@(posedge hclk) disable iff (!hresetn)
        (!app_mmc_q && sel_q[4:0] == 5'h0) |=> !contact_q[0])
        else $error("Contact 0 closed with no function");
    chk_arrive_close: assert property (@(posedge hclk) disable iff (!hresetn)
        (!app_mmc_q && sel_q[4:0] == 5'h1 && arrive) |=> contact_q[0])
        else $error("Arrival did not close contact");
    chk_hyst_inv: assert property (@(posedge hclk) disable iff (!hresetn)
        (!app_mmc_q && sel_q[4:0] == 5'h4 && sel_q[9:5] == 5'h5) |=>
        (contact_q[0] != contact_q[1]))
        else $error("Inverted hysteresis not complement");
    chk_lv_prio: assert property (@(posedge hclk) disable iff (!hresetn)
        (mask_q[0] && stat_q.lv_trip) |=> (cause_q == 3'h1 && relay_q))
        else $error("Low-voltage cause lost priority");
    chk_bx_block: assert property (@(posedge hclk) disable iff (!hresetn)
        (mask_q == 3'h2 && stat_q.drive_disable_fault) |=> !relay_q)
        else $error("Relay on drive disable fault");
    chk_retry_auto: assert property (@(posedge hclk) disable iff (!hresetn)
        (mask_q == 3'h4 && stat_q.auto_retry) |=> !relay_q)
        else $error("Retry relay during auto retry");
    chk_local_kp: assert property (@(posedge hclk) disable iff (!hresetn)
        !remote_d |=> (csrc_q == DSO_KEYPAD && fsrc_q == DSO_KEYPAD))
        else $error("Local mode not on keypad");
    chk_key_off: assert property (@(posedge hclk) disable iff (!hresetn)
        assign_q |=> (rem_q == $past(pin_on)))
        else $error("Remote state not from input");
    chk_key_tog: assert property (@(posedge hclk) disable iff (!hresetn)
        (key_q && !assign_q) |=> (local_key_q != $past(local_key_q)))
        else $error("Key did not toggle");
endmodule : dso_top

// ===== testbench/dso_contact_partner.sv
// Far-side model: control circuitry that drives the local/remote digital input
`timescale 1ns/1ps
module dso_contact_partner (
    input wire logic hclk,
    input wire logic want_remote,
    output logic loc_rem_pin
);
    // Pin changes only on a clock edge and then stays put: no chattering input
    initial loc_rem_pin = 1'b0;
    always @(posedge hclk) begin
        loc_rem_pin <= want_remote;
    end
endmodule : dso_contact_partner

// ===== testbench/drive_status_output_selector_bench.sv
// Testbench: bus writes, then contacts, relay and sources compared with a model
`timescale 1ns/1ps
module drive_status_output_selector_bench;
    import dso_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    dso_ahb_in_t ai = '0;
    dso_ahb_out_t ao;
    logic want_remote = 1'b0;
    logic loc_rem_pin, relay, rem, iot;
    logic [3:0] contact, csrc, fsrc, ex;
    logic [2:0] cause, ec;
    logic [31:0] seed = 32'hB8C4BA87;
    logic [31:0] rd, st, sel, m;
    int num_errors = 0;
    int checks_done = 0;
    int r, o, d, b, fn, cu, cr, lv;
    // Status bit behind each plain status function code
    int sb [21] = '{0, 0, 0, 0, 0, 0, 0, 0, 6, 7, 8, 9, 10, 11, 11, 12, 15, 16, 13, 14, 17};
    logic [31:0] srcw [6] = '{32'h95, 32'h10095, 32'h10095, 32'h20095, 32'h30095, 32'h30095};
    logic pins [6] = '{0, 0, 0, 0, 1, 1};
    logic rems [6] = '{1, 0, 1, 0, 1, 1};
    // Zero-length overload timers: thresholds show at once, a real ms wait would be too long
    dso_top #(.IOL_MS(0)) uut (.hclk(hclk), .hresetn(hresetn), .ahb_i(ai), .ahb_o(ao),
        .loc_rem_pin(loc_rem_pin), .output_contact_a(contact), .fault_relay(relay),
        .fault_cause(cause), .remote_q(rem), .ctrl_source(csrc), .freq_source(fsrc),
        .iol_trip(iot));
    dso_contact_partner far (.hclk(hclk), .want_remote(want_remote), .loc_rem_pin(loc_rem_pin));
    // Free-running clock, 20 ns period
    initial begin
        forever #10 hclk = ~hclk;
    end
    // Single slave: its ready is the bus ready
    // Reset release also wakes it, so a ready settled at time zero is never missed
    always @(ao.hreadyout or hresetn) ai.hready = ao.hreadyout;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Reference behaviour of one contact for a function code
    function automatic logic exp_fn(int f);
        logic arr, hy;
        arr = (r - o <= b / 2) && (o - r <= b / 2);
        hy = st[5] ? (o >= d) : (o > d - b / 2);
        case (f)
            0: return 1'b0;
            6: return cu >= lv;
            7: return cu * 100 > cr * 110;
            1: return arr;
            2: return arr && (o - d <= b / 2) && (d - o <= b / 2);
            3: return (o - d <= b / 2) && (d - o <= b / 2);
            4: return hy;
            5: return !hy;
            14: return !st[11];
            default: return st[sb[f]];
        endcase
    endfunction : exp_fn
    task test_done;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Bounded wait for ready at a rising edge
    task rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (ao.hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            num_errors++;
            test_done;
        end
    endtask : rdy
    task bus(input logic w, input logic [7:0] a, input logic [31:0] dt, output logic [31:0] q);
        @(posedge hclk);
        ai.hsel <= 1'b1;
        ai.haddr <= {24'h0, a};
        ai.htrans <= 2'h2;
        ai.hwrite <= w;
        ai.hsize <= 3'h2;
        rdy;
        ai.hsel <= 1'b0;
        ai.htrans <= 2'h0;
        ai.hwdata <= dt;
        rdy;
        q = ao.hrdata;
    endtask : bus
    task wr(input logic [7:0] a, input logic [31:0] dt);
        bus(1'b1, a, dt, rd);
    endtask : wr
    // Let register and output flops land, then sample away from the edge
    task settle;
        repeat (4) @(posedge hclk);
        @(negedge hclk);
    endtask : settle
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, DSO_OFS_MASK, 32'h0, rd);
        chk("mask", rd, 32'h2);
        bus(1'b0, 8'h40, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        // Key toggling, then the assigned input taking over
        for (int k = 0; k < 6; k++) begin
            want_remote <= pins[k];
            wr(DSO_OFS_SRC, srcw[k]);
            settle;
            chk("remote", rem, rems[k]);
            chk("ctrl", csrc, rems[k] ? 4'h5 : DSO_KEYPAD);
            chk("freq", fsrc, rems[k] ? 4'h9 : DSO_KEYPAD);
        end
        for (int i = 0; i < 24; i++) begin
            r = 100 + xs() % 64;
            o = 100 + xs() % 64;
            d = 100 + xs() % 64;
            b = (xs() % 32) & 30;
            st = xs() & 32'h3FFFF;
            m = xs() % 8;
            cu = 100 + xs() % 64;
            cr = 100 + xs() % 64;
            lv = 100 + xs() % 64;
            sel = 0;
            for (int c = 0; c < 4; c++) begin
                fn = (i * 4 + c) % 21;
                sel[5 * c +: 5] = fn[4:0];
                ex[c] = exp_fn(fn);
            end
            ec = (m[0] & st[4]) ? 3'h1 : (m[1] & st[2] & !st[3]) ? 3'h2 :
                (m[2] & st[1] & !st[0]) ? 3'h4 : 3'h0;
            wr(DSO_OFS_FREQ, {o[15:0], r[15:0]});
            wr(DSO_OFS_FDT, {b[15:0], d[15:0]});
            wr(DSO_OFS_STAT, st);
            wr(DSO_OFS_MASK, m);
            wr(DSO_OFS_SEL, sel);
            wr(DSO_OFS_CUR, {cr[15:0], cu[15:0]});
            wr(DSO_OFS_OLW, {16'h0, lv[15:0]});
            settle;
            chk("iol trip", iot, cu * 100 > cr * 110);
            chk("contacts", contact, ex);
            chk("cause", cause, ec);
            chk("relay", relay, ec != 3'h0);
        end
        // Multi-motor mode turns every contact over to pump control
        wr(DSO_OFS_STAT, 32'h20000);
        wr(DSO_OFS_SRC, 32'h60095);
        settle;
        chk("pump", contact, 4'hF);
        wr(DSO_OFS_STAT, 32'h0);
        settle;
        chk("pump idle", contact, 4'h0);
        test_done;
    end
endmodule : drive_status_output_selector_bench
